// [hw/rail_margin_pkg.sv]
/*
 * shared constants and types for the closed-loop rail margining block.
 * assumes a single 100 MHz clock and word-indexed register access.
 */
package rail_margin_pkg;

	// ************************************************************
	// sizes and timing
	// ************************************************************
	localparam int NUM_RAILS = 24;
	localparam int CLK_HZ = 100_000_000;
	localparam int PWM_FMIN_HZ = 1_000;
	localparam int PWM_FMAX_HZ = 1_000_000;
	localparam logic [16:0] PER_MIN = 17'(CLK_HZ / PWM_FMAX_HZ);
	localparam logic [16:0] PER_MAX = 17'(CLK_HZ / PWM_FMIN_HZ);
	localparam logic [16:0] PER_RST = 17'h001f4;
	localparam logic [10:0] DUTY_FULL = 11'h400;
	localparam int DUTY_SHIFT = 10;
	localparam int LOOP_TIME_US = 1000;
	localparam int LOOP_CYC_DEF = (CLK_HZ / 1_000_000) * LOOP_TIME_US;

	// ************************************************************
	// register map: address = {rail[4:0], reg[2:0]}
	// ************************************************************
	localparam logic [2:0] REG_CFG = 3'h0;
	localparam logic [2:0] REG_PER = 3'h1;
	localparam logic [2:0] REG_FIX = 3'h2;
	localparam logic [2:0] REG_VCMD = 3'h3;
	localparam logic [2:0] REG_MHI = 3'h4;
	localparam logic [2:0] REG_MLO = 3'h5;
	localparam logic [2:0] REG_OP = 3'h6;
	localparam logic [2:0] REG_STAT = 3'h7;

	// config fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_PIN = 2;
	localparam int CFG_IGN = 3;
	localparam int CFG_POL = 4;
	localparam logic [4:0] CFG_RST = 5'h10;
	localparam logic [10:0] FIX_RST = 11'h000;
	localparam logic [15:0] V_RST = 16'h0000;

	// operation byte: margin field
	localparam int OP_MRG_LSB = 4;
	localparam logic [1:0] OP_MRG_LOW = 2'b01;
	localparam logic [1:0] OP_MRG_HIGH = 2'b10;
	localparam logic [7:0] OP_RST = 8'h00;

	typedef enum logic [1:0] {
		MODE_TRI = 2'b00,
		MODE_TRIM = 2'b01,
		MODE_FIXED = 2'b10
	} idle_mode_t;

endpackage

// [hw/margin_pwm.sv]
/*
 * one margin pwm channel with glitch-free period-boundary updates.
 * assumes period, duty and enable come from logic on sys_clk.
 */
`timescale 1ns/10ps
module margin_pwm
	import rail_margin_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// settings
	input wire logic [16:0] period,
	input wire logic [10:0] duty,
	input wire logic oe_req,
	// pin
	output logic pwm_q,
	output logic oe_q
);

	logic [16:0] cnt_q;
	logic [16:0] per_q;
	logic [17:0] cmp_q;
	logic wrap;
	logic [27:0] prod;

	assign wrap = (cnt_q >= per_q - 17'h00001);
	assign prod = 28'(duty) * 28'(period);

	// ************************************************************
	// period counter; settings only change at the wrap
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_q <= 17'h00000;
			per_q <= PER_RST;
			cmp_q <= 18'h00000;
			oe_q <= 1'b0;
		end else if (wrap) begin
			cnt_q <= 17'h00000;
			per_q <= period;
			cmp_q <= prod[DUTY_SHIFT +: 18];
			oe_q <= oe_req;
		end else begin
			cnt_q <= cnt_q + 17'h00001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pwm_q <= 1'b0;
		end else begin
			pwm_q <= oe_q && ({1'b0, cnt_q} < cmp_q);
		end
	end

	property p_oe_hold;
		@(posedge sys_clk) disable iff (!rst_n) !wrap |=> oe_q == $past(oe_q);
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("pwm enable changed mid period");

	property p_off_low;
		@(posedge sys_clk) disable iff (!rst_n) !oe_q |=> !pwm_q;
	endproperty
	a_off_low: assert property (p_off_low) else $error("pwm toggles while released");

endmodule

// [hw/rail_margin.sv]
/*
 * closed-loop margining and trim for 24 rails, one pwm pin each.
 * assumes measurements arrive on sys_clk, one rail per sample, and
 * margin pins are asynchronous.
 */
`timescale 1ns/10ps
module rail_margin
	import rail_margin_pkg::*;
#(
	parameter int LOOP_CYC = LOOP_CYC_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// margin control pins
	input wire logic margin_en_pin,
	input wire logic margin_up_pin,
	// rail measurements
	input wire logic meas_valid,
	input wire logic [4:0] meas_rail,
	input wire logic [15:0] meas_value,
	// outputs
	output logic [NUM_RAILS-1:0] mar_out,
	output logic [NUM_RAILS-1:0] mar_out_oe,
	output logic [NUM_RAILS-1:0] flt_ignore
);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ************************************************************
	// functions
	// ************************************************************
	function automatic logic [16:0] clamp_per(input logic [31:0] v);
		if (v < 32'(PER_MIN)) begin
			return PER_MIN;
		end else if (v > 32'(PER_MAX)) begin
			return PER_MAX;
		end
		return v[16:0];
	endfunction

	function automatic logic [10:0] clamp_duty(input logic [31:0] v);
		if (v > 32'(DUTY_FULL)) begin
			return DUTY_FULL;
		end
		return v[10:0];
	endfunction

	// one step of the slow loop; pol set means more duty gives more volts
	function automatic logic [10:0] next_duty(input logic [10:0] d, input logic [15:0] m,
			input logic [15:0] t, input logic pol);
		logic up;
		logic dn;
		up = pol ? (m < t) : (m > t);
		dn = pol ? (m > t) : (m < t);
		if (up && d < DUTY_FULL) begin
			return d + 11'h001;
		end else if (dn && d != 11'h000) begin
			return d - 11'h001;
		end
		return d;
	endfunction

	// ************************************************************
	// register file
	// ************************************************************
	logic [4:0] cfg_q [NUM_RAILS];
	logic [16:0] per_q [NUM_RAILS];
	logic [10:0] fix_q [NUM_RAILS];
	logic [15:0] vcmd_q [NUM_RAILS];
	logic [15:0] mhi_q [NUM_RAILS];
	logic [15:0] mlo_q [NUM_RAILS];
	logic [7:0] op_q [NUM_RAILS];
	logic [10:0] duty_q [NUM_RAILS];
	logic [NUM_RAILS-1:0] pend_q;
	logic [4:0] a_rail;
	logic [2:0] a_reg;
	logic hit;

	assign a_rail = reg_addr[7:3];
	assign a_reg = reg_addr[2:0];
	assign hit = (a_rail < 5'(NUM_RAILS));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int r = 0; r < NUM_RAILS; r++) begin
				cfg_q[r] <= CFG_RST;
				per_q[r] <= PER_RST;
				fix_q[r] <= FIX_RST;
				vcmd_q[r] <= V_RST;
				mhi_q[r] <= V_RST;
				mlo_q[r] <= V_RST;
				op_q[r] <= OP_RST;
			end
		end else if (reg_wr && hit) begin
			unique case (a_reg)
				REG_CFG: cfg_q[a_rail] <= reg_wdata[4:0];
				REG_PER: per_q[a_rail] <= clamp_per(reg_wdata);
				REG_FIX: fix_q[a_rail] <= clamp_duty(reg_wdata);
				REG_VCMD: vcmd_q[a_rail] <= reg_wdata[15:0];
				REG_MHI: mhi_q[a_rail] <= reg_wdata[15:0];
				REG_MLO: mlo_q[a_rail] <= reg_wdata[15:0];
				REG_OP: op_q[a_rail] <= reg_wdata[7:0];
				REG_STAT: ;
			endcase
		end
	end

	// ************************************************************
	// margin pin synchronisers
	// ************************************************************
	logic en_s1_q;
	logic en_s2_q;
	logic up_s1_q;
	logic up_s2_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			en_s1_q <= 1'b0;
			en_s2_q <= 1'b0;
			up_s1_q <= 1'b0;
			up_s2_q <= 1'b0;
		end else begin
			en_s1_q <= margin_en_pin;
			en_s2_q <= en_s1_q;
			up_s1_q <= margin_up_pin;
			up_s2_q <= up_s1_q;
		end
	end

	// ************************************************************
	// per-rail margin state and targets
	// ************************************************************
	logic [NUM_RAILS-1:0] mrg;
	logic [NUM_RAILS-1:0] high;
	logic [NUM_RAILS-1:0] pin_mrg;
	logic [NUM_RAILS-1:0] loop_act;
	logic [NUM_RAILS-1:0] oe_req;
	logic [NUM_RAILS-1:0] use_vec;
	logic [15:0] target [NUM_RAILS];
	logic [10:0] eff_duty [NUM_RAILS];
	idle_mode_t mode [NUM_RAILS];

	always_comb begin
		for (int r = 0; r < NUM_RAILS; r++) begin
			logic [1:0] f;
			f = op_q[r][OP_MRG_LSB +: 2];
			// pin control overrides the bus for rails assigned to it
			if (cfg_q[r][CFG_PIN]) begin
				mrg[r] = en_s2_q;
				high[r] = up_s2_q;
			end else begin
				mrg[r] = (f == OP_MRG_HIGH) || (f == OP_MRG_LOW);
				high[r] = (f == OP_MRG_HIGH);
			end
			pin_mrg[r] = cfg_q[r][CFG_PIN] && en_s2_q;
			// the spare code falls back to releasing the pin
			unique case (cfg_q[r][CFG_MODE_LSB +: 2])
				MODE_TRIM: mode[r] = MODE_TRIM;
				MODE_FIXED: mode[r] = MODE_FIXED;
				default: mode[r] = MODE_TRI;
			endcase
			loop_act[r] = mrg[r] || (mode[r] == MODE_TRIM);
			oe_req[r] = mrg[r] || (mode[r] != MODE_TRI);
			if (mrg[r]) begin
				target[r] = high[r] ? mhi_q[r] : mlo_q[r];
			end else begin
				target[r] = vcmd_q[r];
			end
			eff_duty[r] = loop_act[r] ? duty_q[r] : fix_q[r];
			use_vec[r] = meas_valid && (meas_rail == 5'(r)) && pend_q[r] && loop_act[r];
		end
	end

	// ************************************************************
	// slow loop tick; far slower than any supply's own loop
	// ************************************************************
	logic [31:0] tick_cnt_q;
	logic tick_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q >= 32'(LOOP_CYC - 1)) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end

	// a tick arriving with a sample re-arms the rail
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pend_q <= '0;
		end else if (tick_q) begin
			pend_q <= '1;
		end else begin
			pend_q <= pend_q & ~use_vec;
		end
	end

	// ************************************************************
	// duty loop; idle rails preload fixed duty for a smooth start
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int r = 0; r < NUM_RAILS; r++) begin
				duty_q[r] <= 11'h000;
			end
		end else begin
			for (int r = 0; r < NUM_RAILS; r++) begin
				if (!loop_act[r]) begin
					duty_q[r] <= fix_q[r];
				end else if (use_vec[r]) begin
					duty_q[r] <= next_duty(duty_q[r], meas_value, target[r], cfg_q[r][CFG_POL]);
				end
			end
		end
	end

	// ************************************************************
	// fault suppression and read port
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flt_ignore <= '0;
		end else begin
			for (int r = 0; r < NUM_RAILS; r++) begin
				flt_ignore[r] <= pin_mrg[r] && cfg_q[r][CFG_IGN];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd && hit) begin
			unique case (a_reg)
				REG_CFG: reg_rdata <= {27'h0000000, cfg_q[a_rail]};
				REG_PER: reg_rdata <= {15'h0000, per_q[a_rail]};
				REG_FIX: reg_rdata <= {21'h000000, fix_q[a_rail]};
				REG_VCMD: reg_rdata <= {16'h0000, vcmd_q[a_rail]};
				REG_MHI: reg_rdata <= {16'h0000, mhi_q[a_rail]};
				REG_MLO: reg_rdata <= {16'h0000, mlo_q[a_rail]};
				REG_OP: reg_rdata <= {24'h000000, op_q[a_rail]};
				REG_STAT: reg_rdata <= {17'h00000, flt_ignore[a_rail], loop_act[a_rail],
					high[a_rail], mrg[a_rail], eff_duty[a_rail]};
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// ************************************************************
	// pwm channels
	// ************************************************************
	for (genvar g = 0; g < NUM_RAILS; g++) begin : g_ch
		margin_pwm u_pwm (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.period(per_q[g]),
			.duty(eff_duty[g]),
			.oe_req(oe_req[g]),
			.pwm_q(mar_out[g]),
			.oe_q(mar_out_oe[g])
		);
	end

	// ************************************************************
	// checks on sample rails; each watches a rail that the loop, pins or modes really drive
	// ************************************************************
	property p_op_high;
		reg_wr && reg_addr == {5'h02, REG_OP} && !cfg_q[2][CFG_PIN]
			&& reg_wdata[OP_MRG_LSB +: 2] == OP_MRG_HIGH |=> mrg[2] && high[2];
	endproperty
	a_op_high: assert property (p_op_high) else $error("operation write did not select high");

	// two synchroniser stages sit between the pin and the margin state
	property p_pin_en;
		$rose(margin_en_pin) && cfg_q[5][CFG_PIN] |-> ##2 (mrg[5] || !cfg_q[5][CFG_PIN]);
	endproperty
	a_pin_en: assert property (p_pin_en) else $error("pin enable did not start margining");

	property p_per_rng;
		reg_wr && reg_addr == {5'h00, REG_PER} |=> per_q[0] >= PER_MIN && per_q[0] <= PER_MAX;
	endproperty
	a_per_rng: assert property (p_per_rng) else $error("pwm period outside range");

	property p_step_dn;
		use_vec[2] && meas_value > target[2] && cfg_q[2][CFG_POL] && duty_q[2] != 11'h000
			|=> !loop_act[2] || duty_q[2] == $past(duty_q[2]) - 11'h001;
	endproperty
	a_step_dn: assert property (p_step_dn) else $error("loop stepped wrong way");

	property p_step_up;
		use_vec[3] && meas_value > target[3] && !cfg_q[3][CFG_POL] && duty_q[3] < DUTY_FULL
			|=> !loop_act[3] || duty_q[3] == $past(duty_q[3]) + 11'h001;
	endproperty
	a_step_up: assert property (p_step_up) else $error("inverted loop stepped wrong way");

	property p_slow;
		loop_act[2] && $past(loop_act[2]) && duty_q[2] != $past(duty_q[2])
			|-> $past(pend_q[2]) && $past(meas_valid);
	endproperty
	a_slow: assert property (p_slow) else $error("duty moved without a tick");

	property p_fixed;
		mode[0] == MODE_FIXED && !mrg[0] |-> eff_duty[0] == fix_q[0] && oe_req[0];
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed duty not applied");

	property p_trim;
		mode[4] == MODE_TRIM && !mrg[4] |-> target[4] == vcmd_q[4] && loop_act[4];
	endproperty
	a_trim: assert property (p_trim) else $error("trim not aimed at command");

	property p_tri;
		mode[0] == MODE_TRI && !mrg[0] |-> !oe_req[0];
	endproperty
	a_tri: assert property (p_tri) else $error("idle tristate pin still driven");

	property p_ign;
		cfg_q[5][CFG_PIN] && cfg_q[5][CFG_IGN] && $rose(en_s2_q) |=> flt_ignore[5];
	endproperty
	a_ign: assert property (p_ign) else $error("faults not ignored under pin margin");

endmodule

// [tb/rail_rc_model.sv]
/*
 * two-pole r-c filter behind every margin pin, measured round robin.
 * assumes the bench says which rails have an inverting feedback path.
 */
`timescale 1ns/10ps
module rail_rc_model
	import rail_margin_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// pins and feedback sense
	input wire logic [NUM_RAILS-1:0] mar_out,
	input wire logic [NUM_RAILS-1:0] mar_out_oe,
	input wire logic [NUM_RAILS-1:0] invert,
	// measurement
	output logic meas_valid,
	output logic [4:0] meas_rail,
	output logic [15:0] meas_value
);
	logic [15:0] f1_q [NUM_RAILS];
	logic [15:0] f2_q [NUM_RAILS];
	logic [4:0] nxt_d;

	assign nxt_d = (meas_rail == 5'(NUM_RAILS - 1)) ? 5'h00 : meas_rail + 5'h01;

	// a released pin feeds nothing: the node bleeds off through the feedback resistor
	always_ff @(posedge sys_clk) begin
		for (int r = 0; r < NUM_RAILS; r++) begin
			if (!rst_n) begin
				f1_q[r] <= 16'h0000;
				f2_q[r] <= 16'h0000;
			end else begin
				f1_q[r] <= f1_q[r] - (f1_q[r] >> 6) + ((mar_out[r] & mar_out_oe[r]) ? 16'h03ff : 16'h0000);
				f2_q[r] <= f2_q[r] - (f2_q[r] >> 6) + (f1_q[r] >> 6);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meas_valid <= 1'b0;
			meas_rail <= 5'h00;
			meas_value <= 16'h0000;
		end else begin
			meas_valid <= 1'b1;
			meas_rail <= nxt_d;
			meas_value <= invert[nxt_d] ? ~f2_q[nxt_d] : f2_q[nxt_d];
		end
	end
endmodule

// [tb/rail_margin_bench.sv]
/*
 * self-checking bench for rail_margin with the r-c filter model on every pin.
 * assumes a 100 MHz clock and a shortened loop tick.
 */
`timescale 1ns/10ps
module rail_margin_bench
	import rail_margin_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic margin_en_pin = 1'b0;
	logic margin_up_pin = 1'b0;
	logic meas_valid;
	logic [4:0] meas_rail;
	logic [15:0] meas_value;
	logic [NUM_RAILS-1:0] mar_out, mar_out_oe, flt_ignore;
	logic [NUM_RAILS-1:0] invert = 24'h000008;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;

	always #5 sys_clk = ~sys_clk;

	rail_margin #(.LOOP_CYC(50)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.margin_en_pin(margin_en_pin), .margin_up_pin(margin_up_pin), .meas_valid(meas_valid),
		.meas_rail(meas_rail), .meas_value(meas_value), .mar_out(mar_out), .mar_out_oe(mar_out_oe),
		.flt_ignore(flt_ignore));

	rail_rc_model rc (.sys_clk(sys_clk), .rst_n(rst_n), .mar_out(mar_out), .mar_out_oe(mar_out_oe),
		.invert(invert), .meas_valid(meas_valid), .meas_rail(meas_rail), .meas_value(meas_value));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		checked++;
		if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wr(input int r, input logic [2:0] i, input logic [31:0] d);
		reg_addr <= {5'(r), i};
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdc(input int r, input logic [2:0] i, input logic [31:0] m, input logic [31:0] lo,
		input logic [31:0] hi);
		logic [31:0] v;
		reg_addr <= {5'(r), i};
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		chk(v & m, lo, hi);
		@(posedge sys_clk);
	endtask

	task automatic cyc_wait(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic t_reset();
		rdc(0, REG_CFG, '1, 32'h10, 32'h10);
		rdc(0, REG_PER, '1, 32'h1f4, 32'h1f4);
		rdc(0, REG_OP, '1, 32'h0, 32'h0);
		rdc(24, REG_CFG, '1, 32'h0, 32'h0);
		wr(0, REG_STAT, '1);
		rdc(0, REG_STAT, '1, 32'h0, 32'h0);
		#1 chk(32'(mar_out_oe | flt_ignore), 32'h0, 32'h0);
	endtask

	task automatic t_per();
		wr(1, REG_PER, 32'ha);
		rdc(1, REG_PER, '1, 32'h64, 32'h64);
		wr(1, REG_PER, 32'h3ffff);
		rdc(1, REG_PER, '1, 32'h186a0, 32'h186a0);
	endtask

	task automatic t_fixed();
		int n;
		n = 0;
		wr(1, REG_PER, 32'h64);
		wr(1, REG_FIX, 32'h200);
		wr(1, REG_CFG, 32'h12);
		// the first period after reset is the 500-clock default; settings land at its end
		cyc_wait(600);
		for (int k = 0; k < 100; k++) begin
			n += int'(mar_out[1] & mar_out_oe[1]);
			cyc_wait(1);
		end
		chk(32'(n), 32'h32, 32'h32);
	endtask

	task automatic t_loop();
		for (int r = 2; r < 7; r++) begin
			wr(r, REG_PER, 32'h64);
		end
		wr(2, REG_MHI, 32'h1000);
		wr(3, REG_MLO, 32'hefff);
		wr(3, REG_CFG, 32'h00);
		wr(4, REG_VCMD, 32'h1000);
		wr(4, REG_CFG, 32'h11);
		wr(2, REG_OP, 32'h20);
		wr(3, REG_OP, 32'h10);
		cyc_wait(200);
		rdc(2, REG_STAT, 32'h7ff, 32'h3, 32'h5);
		cyc_wait(8000);
		rdc(2, REG_STAT, 32'h1fff, 32'h1830, 32'h1850);
		rdc(3, REG_STAT, 32'h1fff, 32'h0830, 32'h0850);
		rdc(4, REG_STAT, 32'h0fff, 32'h30, 32'h50);
		#1 chk(32'(mar_out_oe[4:2]), 32'h7, 32'h7);
		wr(2, REG_OP, 32'h0);
		cyc_wait(110);
		chk(32'(mar_out_oe[2]), 32'h0, 32'h0);
		rdc(2, REG_STAT, 32'h800, 32'h0, 32'h0);
	endtask

	task automatic t_pins();
		wr(5, REG_CFG, 32'h1c);
		wr(6, REG_CFG, 32'h14);
		margin_en_pin <= 1'b1;
		margin_up_pin <= 1'b1;
		cyc_wait(6);
		chk(32'(flt_ignore), 32'h20, 32'h20);
		cyc_wait(110);
		chk(32'(mar_out_oe[6:5]), 32'h3, 32'h3);
		rdc(5, REG_STAT, 32'h1800, 32'h1800, 32'h1800);
		margin_up_pin <= 1'b0;
		cyc_wait(6);
		rdc(6, REG_STAT, 32'h1800, 32'h0800, 32'h0800);
		margin_en_pin <= 1'b0;
		cyc_wait(110);
		chk(32'(flt_ignore | mar_out_oe[6:5]), 32'h0, 32'h0);
	endtask

	task automatic t_all();
		logic [NUM_RAILS-1:0] acc;
		wr(3, REG_OP, 32'h0);
		for (int r = 0; r < NUM_RAILS; r++) begin
			wr(r, REG_CFG, 32'h2);
			wr(r, REG_PER, 32'h64);
			wr(r, REG_FIX, 32'h7ff);
		end
		rdc(23, REG_FIX, '1, 32'h400, 32'h400);
		// untouched rails still run 500-clock periods, so wait one of those plus a short one
		cyc_wait(620);
		acc = '1;
		repeat (20) begin
			acc &= mar_out & mar_out_oe;
			cyc_wait(1);
		end
		chk(32'(acc), 32'hffffff, 32'hffffff);
	endtask

	// ************************************************************
	// main sequence and hang guard
	// ************************************************************
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_per();
		t_fixed();
		t_loop();
		t_pins();
		t_all();
		wrap_up();
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end
endmodule
